//--- logic/bbspp_top.sv
// Purpose: Software-driven clock/data pin pairs for bit-banged two-wire signalling
// Assumes: AXI4-Lite slave, SYS_CLK 10 MHz, pins pulled up externally
// Notes:   Pin inputs pass a two-flop synchroniser before being read back
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module bbspp_top
   import bbspp_pkg::*;
(
   input  wire logic                      SYS_CLK,
   input  wire logic                      SYS_RST,
   input  wire logic [BBSPP_AW-1:0]       S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output logic                           S_AXI_AWREADY,
   input  wire logic [31:0]               S_AXI_WDATA,
   input  wire logic [3:0]                S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output logic                           S_AXI_WREADY,
   output logic [1:0]                     S_AXI_BRESP,
   output logic                           S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [BBSPP_AW-1:0]       S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output logic                           S_AXI_ARREADY,
   output logic [31:0]                    S_AXI_RDATA,
   output logic [1:0]                     S_AXI_RRESP,
   output logic                           S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY,
   input  wire logic [BBSPP_NPAIR-1:0]    PIN_CLK_I,
   output logic      [BBSPP_NPAIR-1:0]    PIN_CLK_O,
   output logic      [BBSPP_NPAIR-1:0]    PIN_CLK_OE,
   input  wire logic [BBSPP_NPAIR-1:0]    PIN_DAT_I,
   output logic      [BBSPP_NPAIR-1:0]    PIN_DAT_O,
   output logic      [BBSPP_NPAIR-1:0]    PIN_DAT_OE
);

   // ==========================================================
   // Address decode: index of pair, or -1 when unmapped
   function automatic int pair_index(input logic [BBSPP_AW-1:0] addr);
      int idx;
      idx = -1;
      case ({addr[BBSPP_AW-1:2], 2'h0})
         BBSPP_OFS_PAIR2: idx = 0;
         BBSPP_OFS_PAIR3: idx = 1;
         BBSPP_OFS_PAIR4: idx = 2;
         default:         idx = -1;
      endcase
      return idx;
   endfunction

   // ==========================================================
   // Pin input synchronisers
   logic [BBSPP_NPAIR-1:0] clk_in_sync;
   logic [BBSPP_NPAIR-1:0] dat_in_sync;

   // Clock pin levels into the core domain
   bbspp_sync #(.W(BBSPP_NPAIR)) u_sync_clk (
      .clk  (SYS_CLK),
      .rst  (SYS_RST),
      .din  (PIN_CLK_I),
      .dout (clk_in_sync)
   );

   // Data pin levels into the core domain
   bbspp_sync #(.W(BBSPP_NPAIR)) u_sync_dat (
      .clk  (SYS_CLK),
      .rst  (SYS_RST),
      .din  (PIN_DAT_I),
      .dout (dat_in_sync)
   );

   // ==========================================================
   // Write channel state
   logic                   aw_held_reg;
   logic                   aw_held_next;
   logic [BBSPP_AW-1:0]    awaddr_reg;
   logic [BBSPP_AW-1:0]    awaddr_next;
   logic                   w_held_reg;
   logic                   w_held_next;
   logic [31:0]            wdata_reg;
   logic [31:0]            wdata_next;
   logic [3:0]             wstrb_reg;
   logic [3:0]             wstrb_next;
   logic                   bvalid_reg;
   logic                   bvalid_next;
   logic [1:0]             bresp_reg;
   logic [1:0]             bresp_next;
   logic                   awready_reg;
   logic                   awready_next;
   logic                   wready_reg;
   logic                   wready_next;
   bbspp_pair_t            pair_reg  [BBSPP_NPAIR];
   bbspp_pair_t            pair_next [BBSPP_NPAIR];
   logic                   do_write;
   int                     widx;

   // Accept address and data in any order, commit once both are held
   always_comb begin
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      for (int i = 0; i < BBSPP_NPAIR; i++) begin
         pair_next[i] = pair_reg[i];
      end
      if (S_AXI_AWVALID && !aw_held_reg && !bvalid_reg) begin
         aw_held_next = 1'b1;
         awaddr_next  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_reg && !bvalid_reg) begin
         w_held_next = 1'b1;
         wdata_next  = S_AXI_WDATA;
         wstrb_next  = S_AXI_WSTRB;
      end
      do_write = aw_held_reg && w_held_reg && !bvalid_reg;
      widx     = pair_index(awaddr_reg);
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = (widx < 0) ? BBSPP_RESP_DE : BBSPP_RESP_OK;
         // All fields live in bytes 0 and 1; reserved bits are ignored
         if (widx >= 0) begin
            if (wstrb_reg[1] && wdata_reg[BBSPP_B_DVMSK]) begin
               pair_next[widx].dval = wdata_reg[BBSPP_B_DVAL];
            end
            if (wstrb_reg[1] && wdata_reg[BBSPP_B_DDMSK]) begin
               pair_next[widx].ddir = wdata_reg[BBSPP_B_DDIR];
            end
            if (wstrb_reg[0] && wdata_reg[BBSPP_B_CVMSK]) begin
               pair_next[widx].cval = wdata_reg[BBSPP_B_CVAL];
            end
            if (wstrb_reg[0] && wdata_reg[BBSPP_B_CDMSK]) begin
               pair_next[widx].cdir = wdata_reg[BBSPP_B_CDIR];
            end
         end
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      // Readies follow the held flags one edge ahead, so the bus sees flops
      awready_next = !aw_held_next && !bvalid_next;
      wready_next  = !w_held_next && !bvalid_next;
   end

   // Register write channel and pair state
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= BBSPP_RESP_OK;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         for (int i = 0; i < BBSPP_NPAIR; i++) begin
            pair_reg[i] <= '{dval: BBSPP_RST_VAL, ddir: BBSPP_RST_DIR,
                             cval: BBSPP_RST_VAL, cdir: BBSPP_RST_DIR};
         end
      end else begin
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         for (int i = 0; i < BBSPP_NPAIR; i++) begin
            pair_reg[i] <= pair_next[i];
         end
      end
   end

   // ==========================================================
   // Read channel
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0]  rresp_reg;
   logic [1:0]  rresp_next;
   logic        arready_reg;
   logic        arready_next;
   int          ridx;

   // Answer one read the cycle after the address is taken
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      ridx        = pair_index(S_AXI_ARADDR);
      if (S_AXI_ARVALID && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rdata_next  = '0;
         rresp_next  = BBSPP_RESP_DE;
         if (ridx >= 0) begin
            rresp_next               = BBSPP_RESP_OK;
            rdata_next[BBSPP_B_DIN]  = dat_in_sync[ridx];
            rdata_next[BBSPP_B_DVAL] = pair_reg[ridx].dval;
            rdata_next[BBSPP_B_DDIR] = pair_reg[ridx].ddir;
            rdata_next[BBSPP_B_CIN]  = clk_in_sync[ridx];
            rdata_next[BBSPP_B_CVAL] = pair_reg[ridx].cval;
            rdata_next[BBSPP_B_CDIR] = pair_reg[ridx].cdir;
         end
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      arready_next = !rvalid_next;
   end

   // Register read channel
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= BBSPP_RESP_OK;
         arready_reg <= 1'b1;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
         arready_reg <= arready_next;
      end
   end

   // ==========================================================
   // Pad drive, registered so outputs come from flops
   bbspp_drive_t drv_reg  [BBSPP_NPAIR];
   bbspp_drive_t drv_next [BBSPP_NPAIR];

   // Drive value only while direction selects output
   always_comb begin
      for (int i = 0; i < BBSPP_NPAIR; i++) begin
         drv_next[i].clk_oe = pair_next[i].cdir;
         drv_next[i].clk_o  = pair_next[i].cval & pair_next[i].cdir;
         drv_next[i].dat_oe = pair_next[i].ddir;
         drv_next[i].dat_o  = pair_next[i].dval & pair_next[i].ddir;
      end
   end

   // Register pad drive
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < BBSPP_NPAIR; i++) begin
            drv_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < BBSPP_NPAIR; i++) begin
            drv_reg[i] <= drv_next[i];
         end
      end
   end

   // ==========================================================
   // Output mapping
   always_comb begin
      for (int i = 0; i < BBSPP_NPAIR; i++) begin
         PIN_CLK_O[i]  = drv_reg[i].clk_o;
         PIN_CLK_OE[i] = drv_reg[i].clk_oe;
         PIN_DAT_O[i]  = drv_reg[i].dat_o;
         PIN_DAT_OE[i] = drv_reg[i].dat_oe;
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY  = wready_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_wr_pair0(int b);
      do_write && widx == 0 && wstrb_reg[b / 8];
   endsequence

   a_dval_masked: assert property (
      s_wr_pair0(BBSPP_B_DVAL) ##0 !wdata_reg[BBSPP_B_DVMSK] |=> $stable(pair_reg[0].dval))
      else $error("Data value changed without mask");
   a_dval_update: assert property (
      s_wr_pair0(BBSPP_B_DVAL) ##0 wdata_reg[BBSPP_B_DVMSK]
      |=> pair_reg[0].dval == $past(wdata_reg[BBSPP_B_DVAL]))
      else $error("Data value not written with mask");
   a_ddir_masked: assert property (
      !(do_write && wdata_reg[BBSPP_B_DDMSK]) |=> $stable(pair_reg[0].ddir))
      else $error("Data direction changed without mask");
   a_ddir_mask: assert property (
      s_wr_pair0(BBSPP_B_DDIR) ##0 wdata_reg[BBSPP_B_DDMSK]
      |=> pair_reg[0].ddir == $past(wdata_reg[BBSPP_B_DDIR]))
      else $error("Data direction not written with mask");
   a_cval_masked: assert property (
      !(do_write && wdata_reg[BBSPP_B_CVMSK]) |=> $stable(pair_reg[0].cval))
      else $error("Clock value changed without mask");
   a_cval_mask: assert property (
      s_wr_pair0(BBSPP_B_CVAL) ##0 wdata_reg[BBSPP_B_CVMSK]
      |=> pair_reg[0].cval == $past(wdata_reg[BBSPP_B_CVAL]))
      else $error("Clock value not written with mask");
   a_cdir_masked: assert property (
      !(do_write && wdata_reg[BBSPP_B_CDMSK]) |=> $stable(pair_reg[0].cdir))
      else $error("Clock direction changed without mask");
   a_cdir_mask: assert property (
      s_wr_pair0(BBSPP_B_CDIR) ##0 wdata_reg[BBSPP_B_CDMSK]
      |=> pair_reg[0].cdir == $past(wdata_reg[BBSPP_B_CDIR]))
      else $error("Clock direction not written with mask");
   a_pin_drive: assert property (
      PIN_CLK_OE[0] == pair_reg[0].cdir && PIN_CLK_O[0] == (pair_reg[0].cval && pair_reg[0].cdir))
      else $error("Clock pin drive does not follow direction");
   a_dat_drive: assert property (
      PIN_DAT_OE[0] == pair_reg[0].ddir && PIN_DAT_O[0] == (pair_reg[0].dval && pair_reg[0].ddir))
      else $error("Data pin drive does not follow direction");
   a_rd_reserved: assert property (
      rvalid_reg |-> (S_AXI_RDATA[31:13] == '0 && S_AXI_RDATA[10] == 1'b0 && S_AXI_RDATA[8:5] == '0
                      && S_AXI_RDATA[2] == 1'b0 && S_AXI_RDATA[0] == 1'b0))
      else $error("Reserved or mask bits read nonzero");
   a_rd_din: assert property (
      S_AXI_ARVALID && !rvalid_reg && pair_index(S_AXI_ARADDR) == 0
      |=> S_AXI_RDATA[BBSPP_B_DIN] == $past(dat_in_sync[0]) && S_AXI_RDATA[BBSPP_B_CIN] == $past(clk_in_sync[0]))
      else $error("Pin level readback wrong");
   a_rd_stored: assert property (
      S_AXI_ARVALID && !rvalid_reg && pair_index(S_AXI_ARADDR) == 0
      |=> S_AXI_RDATA[BBSPP_B_DVAL] == $past(pair_reg[0].dval)
          && S_AXI_RDATA[BBSPP_B_CDIR] == $past(pair_reg[0].cdir))
      else $error("Stored bits read back wrong");

endmodule // bbspp_top

//--- logic/bbspp_pkg.sv
// Purpose: Shared constants and types for the bit-banged serial pin-pair port
// Assumes: 32-bit AXI4-Lite register access, three pin pairs
// Notes:   Offsets are byte addresses
package bbspp_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] BBSPP_OFS_PAIR2 = 16'h5018;
   localparam logic [15:0] BBSPP_OFS_PAIR3 = 16'h501C;
   localparam logic [15:0] BBSPP_OFS_PAIR4 = 16'h5020;
   localparam int          BBSPP_NPAIR     = 3;
   localparam int          BBSPP_AW        = 16;

   // ==========================================================
   // Field positions
   localparam int BBSPP_B_DIN   = 12;
   localparam int BBSPP_B_DVAL  = 11;
   localparam int BBSPP_B_DVMSK = 10;
   localparam int BBSPP_B_DDIR  = 9;
   localparam int BBSPP_B_DDMSK = 8;
   localparam int BBSPP_B_CIN   = 4;
   localparam int BBSPP_B_CVAL  = 3;
   localparam int BBSPP_B_CVMSK = 2;
   localparam int BBSPP_B_CDIR  = 1;
   localparam int BBSPP_B_CDMSK = 0;

   // ==========================================================
   // Reset values and bus answers
   localparam logic       BBSPP_RST_VAL = 1'b1;
   localparam logic       BBSPP_RST_DIR = 1'b0;
   localparam logic [1:0] BBSPP_RESP_OK = 2'h0;
   localparam logic [1:0] BBSPP_RESP_DE = 2'h3;

   // Stored state of one pin pair
   typedef struct packed {
      logic dval;
      logic ddir;
      logic cval;
      logic cdir;
   } bbspp_pair_t;

   // Pin pair drive towards the pads
   typedef struct packed {
      logic clk_o;
      logic clk_oe;
      logic dat_o;
      logic dat_oe;
   } bbspp_drive_t;

endpackage

//--- logic/bbspp_sync.sv
// Purpose: Two-flop synchroniser for pad inputs
// Assumes: Single clock domain SYS_CLK
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module bbspp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_next;

   // ==========================================================
   // Next values: shift one stage
   always_comb begin
      meta_next = din;
      sync_next = meta_reg;
   end

   // Register both stages
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= meta_next;
         dout     <= sync_next;
      end
   end

endmodule // bbspp_sync

//--- test/bbspp_bus_dev.sv
// Purpose: Two-wire bus devices hanging on every clock and data line
// Assumes: External pull-ups; lines are wired-AND of all drivers
// Notes:   The bench commands each device to hold a line low
`timescale 1ns/10ps
module bbspp_bus_dev
   import bbspp_pkg::*;
(
   input  wire logic [BBSPP_NPAIR-1:0] clk_o,
   input  wire logic [BBSPP_NPAIR-1:0] clk_oe,
   input  wire logic [BBSPP_NPAIR-1:0] dat_o,
   input  wire logic [BBSPP_NPAIR-1:0] dat_oe,
   input  wire logic [BBSPP_NPAIR-1:0] hold_clk,
   input  wire logic [BBSPP_NPAIR-1:0] hold_dat,
   output logic      [BBSPP_NPAIR-1:0] clk_line,
   output logic      [BBSPP_NPAIR-1:0] dat_line
);
   // ==========================================================
   // Line levels
   // A released line floats up to 1; any party pulling low wins
   always_comb begin
      clk_line = (clk_o | ~clk_oe) & ~hold_clk;
      dat_line = (dat_o | ~dat_oe) & ~hold_dat;
   end
endmodule // bbspp_bus_dev

//--- test/bbspp_top_tb.sv
// Purpose: Self-checking bench for the pin-pair port
// Assumes: Bus device model on the pins, AXI4-Lite master tasks
// Notes:   Expected reads come from a shadow of the stored bits
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module bbspp_top_tb
   import bbspp_pkg::*;
;
   localparam int TMO = 3000;
   logic                   sys_clk = 1'h0;
   logic                   sys_rst = 1'h1;
   logic [BBSPP_AW-1:0]    awaddr = '0, araddr = '0;
   logic                   awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0]            wdata = '0;
   logic [3:0]             wstrb = '0;
   logic                   awready, wready, bvalid, arready, rvalid;
   logic [1:0]             bresp, rresp;
   logic [31:0]            rdata;
   logic [BBSPP_NPAIR-1:0] clk_o, clk_oe, dat_o, dat_oe, clk_line, dat_line;
   logic [BBSPP_NPAIR-1:0] hold_clk = '0, hold_dat = '0;
   bbspp_pair_t            sh [BBSPP_NPAIR];
   int                     n_mismatch = 0, checks_done = 0, cyc = 0;

   // Clock generation
   always #50 sys_clk = ~sys_clk;

   // ==========================================================
   // Design and bus devices
   bbspp_top DUT (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_CLK_I(clk_line),
      .PIN_CLK_O(clk_o), .PIN_CLK_OE(clk_oe), .PIN_DAT_I(dat_line), .PIN_DAT_O(dat_o), .PIN_DAT_OE(dat_oe));
   bbspp_bus_dev u_dev (.clk_o(clk_o), .clk_oe(clk_oe), .dat_o(dat_o), .dat_oe(dat_oe),
      .hold_clk(hold_clk), .hold_dat(hold_dat), .clk_line(clk_line), .dat_line(dat_line));

   // ==========================================================
   // Bus master tasks; ready is looked at just before the taking edge
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int   n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'h0;
      r = 2'h2;
      @(posedge sys_clk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!tb && n < 40) begin
         @(negedge sys_clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         n++;
      end
      bready <= 1'h0;
      if (!tb) n_mismatch++;
   endtask

   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta, tr;
      n = 0;
      tr = 1'h0;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!tr && n < 40) begin
         @(negedge sys_clk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (ta) arvalid <= 1'h0;
         n++;
      end
      rready <= 1'h0;
      if (!tr) n_mismatch++;
   endtask

   // Write one pair and follow the masks in the shadow
   task automatic wr_pair(input int p, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axi_wr(BBSPP_OFS_PAIR2 + 16'(4 * p), d & 32'h0000_0F0F, s, r);
      if (s[1] && d[10]) sh[p].dval = d[11];
      if (s[1] && d[8]) sh[p].ddir = d[9];
      if (s[0] && d[2]) sh[p].cval = d[3];
      if (s[0] && d[0]) sh[p].cdir = d[1];
      `CHK("bresp", BBSPP_RESP_OK, r)
   endtask

   // Read one pair back and look at its pins
   task automatic chk_pair(input int p);
      logic [31:0] d;
      logic [1:0]  r;
      logic        din, cin;
      repeat (2) @(posedge sys_clk);
      din = (sh[p].dval | ~sh[p].ddir) & ~hold_dat[p];
      cin = (sh[p].cval | ~sh[p].cdir) & ~hold_clk[p];
      axi_rd(BBSPP_OFS_PAIR2 + 16'(4 * p), d, r);
      `CHK("rresp", BBSPP_RESP_OK, r)
      `CHK("data in", din, d[12])
      `CHK("data value", sh[p].dval, d[11])
      `CHK("data dir", sh[p].ddir, d[9])
      `CHK("clock in", cin, d[4])
      `CHK("clock value", sh[p].cval, d[3])
      `CHK("clock dir", sh[p].cdir, d[1])
      `CHK("masks", 4'h0, {d[10], d[8], d[2], d[0]})
      `CHK("reserved", 22'h0, {d[31:13], d[7:5]})
      @(negedge sys_clk);
      `CHK("clock oe", sh[p].cdir, clk_oe[p])
      `CHK("clock out", sh[p].cval & sh[p].cdir, clk_o[p])
      `CHK("data oe", sh[p].ddir, dat_oe[p])
      `CHK("data out", sh[p].dval & sh[p].ddir, dat_o[p])
      @(posedge sys_clk);
   endtask

   // ==========================================================
   // Scenarios
   // No mask, value masks, direction masks, drive high, release
   task automatic t_masks(input int p);
      logic [31:0] seq [5] = '{32'h0A0A, 32'h0404, 32'h0303, 32'h0C0C, 32'h0101};
      foreach (seq[i]) begin
         wr_pair(p, seq[i], 4'hF);
         chk_pair(p);
      end
      $display("test masks pair %0d done", p);
   endtask

   // Devices hold lines low, also against our own high drive
   task automatic t_partner();
      hold_clk[1] <= 1'h1;
      chk_pair(1);
      hold_clk[1] <= 1'h0;
      hold_dat[1] <= 1'h1;
      wr_pair(1, 32'h0303, 4'hF);
      chk_pair(1);
      hold_dat[1] <= 1'h0;
      chk_pair(1);
      $display("test partner done");
   endtask

   // Byte strobes gate the clock and data fields apart
   task automatic t_strobe();
      wr_pair(2, 32'h0707, 4'h1);
      chk_pair(2);
      wr_pair(2, 32'h0505, 4'h2);
      chk_pair(2);
      $display("test strobe done");
   endtask

   // Unmapped places answer decode error and change nothing
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(16'h5024, 32'h0000_0F0F, 4'hF, r);
      `CHK("unmapped bresp", BBSPP_RESP_DE, r)
      axi_rd(16'h5014, d, r);
      `CHK("unmapped rresp", BBSPP_RESP_DE, r)
      `CHK("unmapped rdata", 32'h0, d)
      for (int p = 0; p < BBSPP_NPAIR; p++) chk_pair(p);
      $display("test unmapped done");
   endtask

   // ==========================================================
   // Closing report
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Main sequence
   initial begin
      foreach (sh[i]) sh[i] = '{dval: 1'h1, ddir: 1'h0, cval: 1'h1, cdir: 1'h0};
      repeat (6) @(posedge sys_clk);
      `CHK("oe in reset", 6'h0, {clk_oe, dat_oe})
      sys_rst <= 1'h0;
      for (int p = 0; p < BBSPP_NPAIR; p++) chk_pair(p);
      $display("test reset done");
      for (int p = 0; p < BBSPP_NPAIR; p++) t_masks(p);
      t_partner();
      t_strobe();
      t_unmapped();
      wrap_up();
   end
endmodule // bbspp_top_tb
